// ===== rtl/wake_pin_cfg.svh
`ifndef WAKE_PIN_CFG_SVH
`define WAKE_PIN_CFG_SVH
// register offsets (register port address)
`define WAKE_INPUT_SETUP_ADDR 8'h11
`define WAKE_BEHAVIOUR_SETUP_ADDR 8'h12
`define WAKE_INPUT_SETUP_RST 8'h04
`define WAKE_BEHAVIOUR_SETUP_RST 8'h02
// input setup fields
`define EDGE_SEL_HI 7
`define EDGE_SEL_LO 6
`define STAT_HI 5
`define STAT_LO 4
`define REJECT_HI 3
`define REJECT_LO 2
`define MAXW_HI 1
`define MAXW_LO 0
// behaviour setup fields
`define POL_BIT 7
`define SENSE_BIT 6
`define CYC_TIME_BIT 5
`define IRQ_SEL_HI 4
`define IRQ_SEL_LO 3
`define RX_IND_BIT 2
`define LEVEL_HI 1
`define LEVEL_LO 0
// timing
`define CLK_HZ 125000000
`define MS_CYCLES (`CLK_HZ / 1000)
`define REJECT_BASE_MS 5
`define MAXW_0_MS 750
`define MAXW_1_MS 1000
`define MAXW_2_MS 1500
`define MAXW_3_MS 2000
`define CYC_T0_US 30
`define CYC_T1_US 75
`define CYC_T0_CYCLES ((`CYC_T0_US * (`CLK_HZ / 1000000)))
`define CYC_T1_CYCLES ((`CYC_T1_US * (`CLK_HZ / 1000000)))
`define CYC_PERIOD_MS 10
`define RX_TOGGLE_US 10
`define RX_TOGGLE_CYCLES (`RX_TOGGLE_US * (`CLK_HZ / 1000000))
`endif

// ===== rtl/wake_pin_pkg.sv
package wake_pin_pkg;
    typedef enum logic [1:0] {EDGE_BOTH, EDGE_RISE, EDGE_FALL, EDGE_PULSE} edge_mode_t;
    typedef enum logic [1:0] {EV_NONE, EV_RISE, EV_FALL, EV_PULSE} wake_event_t;
    typedef enum logic [1:0] {IRQ_GLOBAL, IRQ_WDOG, IRQ_RSVD, IRQ_WAKE} irq_fn_t;
    // register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
    // configuration seen by the qualifier
    typedef struct packed {
        edge_mode_t mode;
        logic [1:0] reject_sel;
        logic [1:0] max_sel;
        logic pol;
        logic cyclic;
        logic cyc_time;
    } wake_cfg_t;
endpackage : wake_pin_pkg

// ===== rtl/wake_pin_detector.sv
// Summary of operation
// - edge select picks either, rise, fall, pulse
// - status holds last event, software writes zero
// - pulse at or below reject width invalid
// - pulse above maximum width is invalid
// - polarity bit sets pulse shape in pulse mode
// - sense bit picks static or cyclic sampling
// - fail-safe entry clears cyclic back to static
// - cyclic sample time 30 or 75 us
// - irq pin function chosen by two bits
// - rx line held low or toggles on wake
// - threshold midpoint field resets to 3 V
`timescale 1ns/10ps
`include "wake_pin_cfg.svh"
module wake_pin_detector #(
    parameter int unsigned MS_CYC = `MS_CYCLES,          // cycles per millisecond
    parameter int unsigned CYC_PERIOD = `CYC_PERIOD_MS * `MS_CYCLES // cyclic sensing period
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire wake_pin_pkg::reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire logic wake_in,
    input wire logic fail_safe_entry,
    input wire logic global_irq,
    input wire logic wdog_fail,
    output logic irq_out_n,
    output logic rxd_out,
    output logic [1:0] wake_level_sel,
    output logic sample_enable,
    output logic wake_event
);
    import wake_pin_pkg::*;

    // reset images of both registers; fields are picked out of them below
    localparam logic [7:0] IN_RST = `WAKE_INPUT_SETUP_RST;
    localparam logic [7:0] BEH_RST = `WAKE_BEHAVIOUR_SETUP_RST;

    // register fields
    logic [1:0] edge_sel_r;
    logic [1:0] stat_r;
    logic [1:0] reject_sel_r;
    logic [1:0] max_sel_r;
    logic pol_r;
    logic sense_r;
    logic cyclic_sample_time_sel;
    logic [1:0] irq_pin_function_sel;
    logic rx_wake_indication_sel;
    logic [1:0] level_r;
    wake_cfg_t cfg;

    // detection state
    logic pin_r;             // last accepted pin level
    logic in_pulse_r;        // pulse measurement running
    logic [31:0] width_r;    // pulse width in cycles
    logic [31:0] cyc_cnt_r;  // cyclic period counter
    wake_event_t ev_nxt;
    logic ev_valid;
    logic wake_pend_r;       // wake indication pending
    logic [15:0] tog_cnt_r;
    logic rx_tog_r;

    logic wr_in, wr_beh;
    assign wr_in = reg_req.wr && (reg_req.addr == `WAKE_INPUT_SETUP_ADDR);
    assign wr_beh = reg_req.wr && (reg_req.addr == `WAKE_BEHAVIOUR_SETUP_ADDR);

    // one driver for the whole configuration bundle
    assign cfg = '{mode: edge_mode_t'(edge_sel_r), reject_sel: reject_sel_r, max_sel: max_sel_r,
                   pol: pol_r, cyclic: sense_r, cyc_time: cyclic_sample_time_sel};

    // input setup register, plain fields
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            edge_sel_r <= IN_RST[`EDGE_SEL_HI:`EDGE_SEL_LO];
            reject_sel_r <= IN_RST[`REJECT_HI:`REJECT_LO];
            max_sel_r <= IN_RST[`MAXW_HI:`MAXW_LO];
        end else if (wr_in) begin
            edge_sel_r <= reg_req.wdata[`EDGE_SEL_HI:`EDGE_SEL_LO];
            reject_sel_r <= reg_req.wdata[`REJECT_HI:`REJECT_LO];
            max_sel_r <= reg_req.wdata[`MAXW_HI:`MAXW_LO];
        end
    end

    // status field: hardware event wins over a software zero write
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            stat_r <= IN_RST[`STAT_HI:`STAT_LO];
        end else if (ev_valid) begin
            stat_r <= ev_nxt;
        end else if (wr_in && reg_req.wdata[`STAT_HI:`STAT_LO] == 2'h0) begin
            stat_r <= 2'h0;
        end
    end

    // status follows the event that was qualified one cycle before
    property p_stat_set;
        @(posedge sys_clk) disable iff (!reset_n) ev_valid |=> stat_r == $past(ev_nxt);
    endproperty
    a_stat_set: assert property (p_stat_set) else $error("status not updated");

    // behaviour setup register
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pol_r <= BEH_RST[`POL_BIT];
            cyclic_sample_time_sel <= BEH_RST[`CYC_TIME_BIT];
            irq_pin_function_sel <= BEH_RST[`IRQ_SEL_HI:`IRQ_SEL_LO];
            rx_wake_indication_sel <= BEH_RST[`RX_IND_BIT];
            level_r <= BEH_RST[`LEVEL_HI:`LEVEL_LO];
        end else if (wr_beh) begin
            pol_r <= reg_req.wdata[`POL_BIT];
            cyclic_sample_time_sel <= reg_req.wdata[`CYC_TIME_BIT];
            irq_pin_function_sel <= reg_req.wdata[`IRQ_SEL_HI:`IRQ_SEL_LO];
            rx_wake_indication_sel <= reg_req.wdata[`RX_IND_BIT];
            level_r <= reg_req.wdata[`LEVEL_HI:`LEVEL_LO];
        end
    end

    // sense bit: fail-safe entry overrides software write
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            sense_r <= BEH_RST[`SENSE_BIT];
        end else if (fail_safe_entry) begin
            sense_r <= 1'b0;
        end else if (wr_beh) begin
            sense_r <= reg_req.wdata[`SENSE_BIT];
        end
    end

    // fail-safe entry always returns to static sensing
    property p_fs_clear;
        @(posedge sys_clk) disable iff (!reset_n) fail_safe_entry |=> !sense_r;
    endproperty
    a_fs_clear: assert property (p_fs_clear) else $error("sense not cleared on fail-safe");

    assign wake_level_sel = level_r;

    // read mux, unmapped reads return zero
    always_comb begin
        reg_rdata = 8'h00;
        if (reg_req.rd && reg_req.addr == `WAKE_INPUT_SETUP_ADDR) begin
            reg_rdata = {edge_sel_r, stat_r, reject_sel_r, max_sel_r};
        end else if (reg_req.rd && reg_req.addr == `WAKE_BEHAVIOUR_SETUP_ADDR) begin
            reg_rdata = {pol_r, sense_r, cyclic_sample_time_sel, irq_pin_function_sel,
                         rx_wake_indication_sel, level_r};
        end
    end

    // cyclic sensing window: sample only during the first part of each period
    always_ff @(posedge sys_clk) begin
        if (!reset_n || !cfg.cyclic) begin
            cyc_cnt_r <= 32'h0;
        end else if (cyc_cnt_r >= CYC_PERIOD - 1) begin
            cyc_cnt_r <= 32'h0;
        end else begin
            cyc_cnt_r <= cyc_cnt_r + 32'h1;
        end
    end

    // static sensing samples every cycle; cyclic only inside the window
    always_comb begin
        if (!cfg.cyclic) begin
            sample_enable = 1'b1;
        end else if (cfg.cyc_time) begin
            sample_enable = cyc_cnt_r < `CYC_T1_CYCLES;
        end else begin
            sample_enable = cyc_cnt_r < `CYC_T0_CYCLES;
        end
    end

    // static sensing never gates the pin
    property p_static;
        @(posedge sys_clk) disable iff (!reset_n) !sense_r |-> sample_enable;
    endproperty
    a_static: assert property (p_static) else $error("static sensing gated");

    // width limits in cycles; minimum valid is one cycle above the reject width
    logic [31:0] reject_cyc, max_cyc;
    always_comb begin
        reject_cyc = (`REJECT_BASE_MS << cfg.reject_sel) * MS_CYC;
        unique case (cfg.max_sel)
            2'h0: max_cyc = `MAXW_0_MS * MS_CYC;
            2'h1: max_cyc = `MAXW_1_MS * MS_CYC;
            2'h2: max_cyc = `MAXW_2_MS * MS_CYC;
            2'h3: max_cyc = `MAXW_3_MS * MS_CYC;
        endcase
    end

    logic rise, fall, lead_edge, trail_edge;
    assign rise = sample_enable && wake_in && !pin_r;
    assign fall = sample_enable && !wake_in && pin_r;
    // polarity 0 expects low-high-low, 1 expects high-low-high
    assign lead_edge = cfg.pol ? fall : rise;
    assign trail_edge = cfg.pol ? rise : fall;

    // pin level tracking; reset loads the live level so no false edge follows reset
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pin_r <= wake_in;
        end else if (sample_enable) begin
            pin_r <= wake_in;
        end
    end

    // pulse width measurement, saturating one cycle above the selected maximum
    always_ff @(posedge sys_clk) begin
        if (!reset_n || cfg.mode != EDGE_PULSE) begin
            in_pulse_r <= 1'b0;
            width_r <= 32'h0;
        end else if (lead_edge) begin
            in_pulse_r <= 1'b1;
            width_r <= 32'h1; // leading cycle is the first cycle of the pulse
        end else if (trail_edge) begin
            in_pulse_r <= 1'b0;
        end else if (in_pulse_r && width_r <= max_cyc) begin
            width_r <= width_r + 32'h1;
        end
    end

    // event classification
    always_comb begin
        ev_valid = 1'b0;
        ev_nxt = EV_NONE;
        unique case (cfg.mode)
            EDGE_BOTH: begin
                ev_valid = rise || fall;
                ev_nxt = rise ? EV_RISE : EV_FALL;
            end
            EDGE_RISE: begin
                ev_valid = rise;
                ev_nxt = EV_RISE;
            end
            EDGE_FALL: begin
                ev_valid = fall;
                ev_nxt = EV_FALL;
            end
            EDGE_PULSE: begin
                // width above reject and not beyond maximum
                ev_valid = in_pulse_r && trail_edge && (width_r > reject_cyc) && (width_r <= max_cyc);
                ev_nxt = EV_PULSE;
            end
        endcase
    end

    // short pulses never qualify
    property p_short_pulse;
        @(posedge sys_clk) disable iff (!reset_n)
            (cfg.mode == EDGE_PULSE && width_r <= reject_cyc) |-> !ev_valid;
    endproperty
    a_short_pulse: assert property (p_short_pulse) else $error("short pulse accepted");

    // over-long pulses never qualify
    property p_long_pulse;
        @(posedge sys_clk) disable iff (!reset_n)
            (cfg.mode == EDGE_PULSE && width_r > max_cyc) |-> !ev_valid;
    endproperty
    a_long_pulse: assert property (p_long_pulse) else $error("long pulse accepted");

    // a falling edge in rising mode leaves no falling status behind
    property p_rise_only;
        @(posedge sys_clk) disable iff (!reset_n)
            (cfg.mode == EDGE_RISE && fall) |=> stat_r != EV_FALL || $past(stat_r) == EV_FALL;
    endproperty
    a_rise_only: assert property (p_rise_only) else $error("fall seen in rise mode");

    // wake pending until status is cleared by software
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            wake_pend_r <= 1'b0;
            wake_event <= 1'b0;
        end else begin
            wake_event <= ev_valid;
            if (ev_valid) begin
                wake_pend_r <= 1'b1;
            end else if (wr_in && reg_req.wdata[`STAT_HI:`STAT_LO] == 2'h0) begin
                wake_pend_r <= 1'b0;
            end
        end
    end

    // rx indication toggle generator
    always_ff @(posedge sys_clk) begin
        if (!reset_n || !wake_pend_r) begin
            tog_cnt_r <= 16'h0;
            rx_tog_r <= 1'b0;
        end else if (tog_cnt_r >= 16'(`RX_TOGGLE_CYCLES - 1)) begin
            tog_cnt_r <= 16'h0;
            rx_tog_r <= ~rx_tog_r;
        end else begin
            tog_cnt_r <= tog_cnt_r + 16'h1;
        end
    end

    // rx line: idle high; on wake held low or toggling
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rxd_out <= 1'b1;
        end else begin
            rxd_out <= !wake_pend_r ? 1'b1 : (rx_wake_indication_sel ? rx_tog_r : 1'b0);
        end
    end

    // held-low indication once the pending wake has settled
    property p_rx_low;
        @(posedge sys_clk) disable iff (!reset_n)
            (wake_pend_r && !rx_wake_indication_sel) [*2] |-> !rxd_out;
    endproperty
    a_rx_low: assert property (p_rx_low) else $error("rx not low on wake");

    // interrupt pin function select; reserved code leaves pin inactive
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            irq_out_n <= 1'b1;
        end else begin
            unique case (irq_fn_t'(irq_pin_function_sel))
                IRQ_GLOBAL: irq_out_n <= !global_irq;
                IRQ_WDOG: irq_out_n <= !wdog_fail;
                IRQ_RSVD: irq_out_n <= 1'b1;
                IRQ_WAKE: irq_out_n <= !wake_pend_r;
            endcase
        end
    end

    // wake request function drives the pin low one cycle later
    property p_irq_wake;
        @(posedge sys_clk) disable iff (!reset_n)
            (irq_pin_function_sel == 2'h3 && wake_pend_r) |=> !irq_out_n;
    endproperty
    a_irq_wake: assert property (p_irq_wake) else $error("wake request not on irq pin");
endmodule : wake_pin_detector

// ===== testbench/wake_source.sv
`timescale 1ns/10ps
// local wake switch: clean levels, no bounce
module wake_source (
    input wire logic sys_clk,
    output logic wake_in
);
    initial wake_in = 1'b0;
    // park the pin at a level between pulses
    task automatic idle(input logic lvl);
        @(negedge sys_clk);
        wake_in = lvl;
    endtask : idle
    // leave the idle level s for w cycles, then come back
    task automatic pulse(input logic s, input int w);
        @(negedge sys_clk);
        wake_in = ~s;
        repeat (w) @(negedge sys_clk);
        wake_in = s;
    endtask : pulse
endmodule : wake_source

// ===== testbench/wake_pin_detector_bench.sv
`timescale 1ns/10ps
`include "wake_pin_cfg.svh"
module wake_pin_detector_bench;
    import wake_pin_pkg::*;
    localparam int MS = 5; // shortened millisecond, keeps the run short
    localparam int PER = 10000; // shortened cyclic period, above 75 us
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic fail_safe_entry = 1'b0;
    logic global_irq = 1'b0;
    logic wdog_fail = 1'b0;
    reg_req_t reg_req = '0;
    logic [7:0] reg_rdata;
    logic [7:0] v;
    logic [1:0] wake_level_sel;
    logic wake_in, irq_out_n, rxd_out, sample_enable, wake_event;
    int failures = 0;
    int total_checks = 0;
    int exp_stat, n, k;
    int wmax[4] = '{750, 1000, 1500, 2000}; // maximum widths in ms
    always #4 sys_clk = ~sys_clk;
    wake_pin_detector #(.MS_CYC(MS), .CYC_PERIOD(PER)) wake_pin_detector_i (.sys_clk(sys_clk),
        .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata), .wake_in(wake_in),
        .fail_safe_entry(fail_safe_entry), .global_irq(global_irq), .wdog_fail(wdog_fail),
        .irq_out_n(irq_out_n), .rxd_out(rxd_out), .wake_level_sel(wake_level_sel),
        .sample_enable(sample_enable), .wake_event(wake_event));
    wake_source wake_source_i (.sys_clk(sys_clk), .wake_in(wake_in));
    // verdict and end of run
    task automatic test_done;
        if (failures == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done
    // compare seen against expected
    task automatic check(input logic [15:0] seen, input int exp);
        total_checks++;
        if (seen !== 16'(exp)) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, 16'(exp));
        end
    endtask : check
    // register write, taken at the posedge in the middle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge sys_clk);
        reg_req = '0;
    endtask : wr
    // register read, data sampled just before the edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        #3;
        d = reg_rdata;
        @(negedge sys_clk);
        reg_req = '0;
    endtask : rd
    // model: status after an edge in mode m, rising when r
    function automatic int edge_model(input int m, input int prev, input bit r);
        if ((m == 1 && !r) || (m == 2 && r)) return prev;
        return r ? 1 : 2;
    endfunction : edge_model
    // pulse of shape s, width w, with polarity p and config c
    task automatic pul(input bit p, input bit s, input int rj, input int mx, input int w, input logic [6:0] c);
        int lo;
        int hi;
        int ok;
        lo = (5 << rj) * MS;
        hi = wmax[mx] * MS;
        ok = s == p && w > lo && w <= hi;
        wake_source_i.idle(s);
        wr(8'h12, {p, c});
        wr(8'h11, 8'(192 + rj * 4 + mx)); // status cleared by this write
        wake_source_i.pulse(s, w);
        @(negedge sys_clk);
        check(wake_event, ok);
        repeat (5) @(negedge sys_clk);
        rd(8'h11, v);
        check(v[5:4], ok ? 3 : 0);
    endtask : pul
    // length of one sampling window in cyclic sensing
    task automatic meas(input int exp);
        int c;
        c = 0;
        for (k = 0; k < 2 * PER && sample_enable !== 1'b0; k++) @(negedge sys_clk);
        for (k = 0; k < 2 * PER && sample_enable !== 1'b1; k++) @(negedge sys_clk);
        if (k == 2 * PER) begin
            failures++;
            test_done();
        end
        while (c < 2 * PER && sample_enable === 1'b1) begin
            c++;
            @(negedge sys_clk);
        end
        check(16'(c), exp);
    endtask : meas
    // main sequence
    initial begin
        void'($urandom(12000));
        repeat (4) @(negedge sys_clk);
        reset_n = 1'b1;
        check(irq_out_n, 1);
        check(rxd_out, 1);
        check(wake_level_sel, 2);
        rd(8'h11, v);
        check(v, 8'h04);
        rd(8'h12, v);
        check(v, 8'h02);
        rd(8'h13, v);
        check(v, 0);
        // random static settings read back; level select follows
        for (int i = 0; i < 4; i++) begin
            n = $urandom & 8'hbf;
            wr(8'h12, 8'(n));
            rd(8'h12, v);
            check(v, n & 8'hff);
            check(wake_level_sel, n & 3);
            check(sample_enable, 1);
        end
        wr(8'h12, 8'h02);
        // either, rise and fall modes each see a rise then a fall
        for (int m = 0; m < 3; m++) begin
            wr(8'h11, 8'(m << 6));
            exp_stat = 0;
            for (int e = 0; e < 2; e++) begin
                wake_source_i.idle(e == 0);
                @(negedge sys_clk);
                check(wake_event, m == 0 || (m == 1) == (e == 0));
                repeat (5) @(negedge sys_clk);
                exp_stat = edge_model(m, exp_stat, e == 0);
                rd(8'h11, v);
                check(v[5:4], exp_stat);
            end
        end
        // every reject code exactly at its width and one cycle above
        for (int r = 0; r < 4; r++) begin
            pul(r[0], r[0], r, 0, (5 << r) * MS, 7'h02);
            pul(r[0], r[0], r, 0, (5 << r) * MS + 1, 7'h02);
        end
        pul(0, 1, 0, 0, 60, 7'h02); // wrong shape for the polarity
        pul(0, 0, 0, 0, wmax[0] * MS + 1, 7'h02);
        for (int x = 0; x < 4; x++) pul(x[0], x[0], 1, x, wmax[x] * MS, 7'h02);
        // pulse pending: every irq pin function with random sources
        for (int s = 0; s < 4; s++) begin
            n = $urandom;
            @(negedge sys_clk);
            global_irq = n[0];
            wdog_fail = n[1];
            wr(8'h12, 8'(s * 8 + 2));
            repeat (2) @(negedge sys_clk);
            check(irq_out_n, s == 0 ? !n[0] : s == 1 ? !n[1] : s == 3 ? 0 : 1);
            check(rxd_out, 0);
        end
        wr(8'h11, 8'hc0);
        repeat (2) @(negedge sys_clk);
        check(irq_out_n, 1);
        check(rxd_out, 1);
        // toggling receive line while a wake is pending
        pul(0, 0, 0, 0, 60, 7'h06);
        n = 0;
        for (int t = 0; t < 3 * `RX_TOGGLE_CYCLES; t++) begin
            @(negedge sys_clk);
            n += rxd_out;
        end
        check(n > 0 && n < 3 * `RX_TOGGLE_CYCLES, 1);
        // cyclic sensing at both sample times; no switch timers here
        wr(8'h12, 8'h42);
        meas(`CYC_T0_CYCLES);
        wr(8'h12, 8'h62);
        meas(`CYC_T1_CYCLES);
        @(negedge sys_clk);
        fail_safe_entry = 1'b1;
        @(negedge sys_clk);
        fail_safe_entry = 1'b0;
        rd(8'h12, v);
        check(v, 8'h22);
        check(sample_enable, 1);
        test_done();
    end
endmodule : wake_pin_detector_bench
